//--- logic/twbc_ctrl.v
// host sequencer driving a two-wire bus controller through its registers
`timescale 1ns/1ps
`default_nettype none
`include "twbc_defs.vh"

module twbc_ctrl (
    input wire clk_in,
    input wire rst_in,
    input wire [7:0] h_addr_in,
    input wire [15:0] h_wdata_in,
    input wire h_wr_in,
    input wire h_rd_in,
    output wire [15:0] h_rdata_out,
    output wire [7:0] dev_addr_out,
    output wire [7:0] dev_wdata_out,
    output wire dev_wr_out,
    output wire dev_rd_out,
    input wire [7:0] dev_rdata_in
);

localparam S_IDLE = 5'd0;
localparam S_INIT2 = 5'd1;
localparam S_CRW = 5'd2;
localparam S_RDW = 5'd3;
localparam S_BBCHK = 5'd4;
localparam S_STA = 5'd5;
localparam S_ADDR = 5'd6;
localparam S_BB2CHK = 5'd7;
localparam S_POLL = 5'd8;
localparam S_PCHK = 5'd9;
localparam S_DISP = 5'd10;
localparam S_TXB = 5'd11;
localparam S_RXRD = 5'd12;
localparam S_RXST = 5'd13;
localparam S_STOP = 5'd14;
localparam S_FIN = 5'd15;
localparam S_DONE = 5'd16;

reg [4:0] state_q;
reg [4:0] ret_q;
reg rdw_q;
reg [7:0] rd_q;
reg [7:0] cr_q;
reg [7:0] dev_addr_q;
reg [7:0] dev_wdata_q;
reg dev_wr_q;
reg dev_rd_q;
reg [15:0] h_rdata_q;
reg [15:0] rmux;
reg rnw_q, hold_q, slv_en_q, en_q;
reg [5:0] div_q;
reg [6:0] own_q;
reg [6:0] tgt_q;
reg [7:0] len_q, cnt_q;
reg [7:0] txd_q, rxd_q;
reg tx_full_q, rx_full_q;
reg done_q, nack_q, al_q;
reg master_q, slave_q, holding_q, addr_ph_q;
reg mrnw_q, mhold_q, dummy_q, last_q;

wire ctrl_wr = h_wr_in && (h_addr_in == `TWBC_H_CTRL);
wire start_w = ctrl_wr && h_wdata_in[`TWBC_C_START];
wire init_w = ctrl_wr && h_wdata_in[`TWBC_C_INIT];

assign dev_addr_out = dev_addr_q;
assign dev_wdata_out = dev_wdata_q;
assign dev_wr_out = dev_wr_q;
assign dev_rd_out = dev_rd_q;
assign h_rdata_out = h_rdata_q;

////////////////////////////////////////////////////////////////////////////////
always @* begin
    rmux = 16'h0000;
    case (h_addr_in)
        `TWBC_H_CTRL: begin
            rmux[`TWBC_C_RNW] = rnw_q;
            rmux[`TWBC_C_HOLD] = hold_q;
            rmux[`TWBC_C_SLVEN] = slv_en_q;
        end
        `TWBC_H_CFG: rmux = {1'b0, own_q, 2'b00, div_q};
        `TWBC_H_TGT: rmux = {9'h000, tgt_q};
        `TWBC_H_LEN: rmux = {8'h00, len_q};
        `TWBC_H_TXD: rmux = {8'h00, txd_q};
        `TWBC_H_RXD: rmux = {8'h00, rxd_q};
        `TWBC_H_STAT: begin
            rmux[`TWBC_S_BUSY] = (state_q != S_IDLE);
            rmux[`TWBC_S_DONE] = done_q;
            rmux[`TWBC_S_NACK] = nack_q;
            rmux[`TWBC_S_AL] = al_q;
            rmux[`TWBC_S_TXF] = tx_full_q;
            rmux[`TWBC_S_RXF] = rx_full_q;
            rmux[`TWBC_S_HELD] = holding_q;
            rmux[`TWBC_S_EN] = en_q;
        end
        default: rmux = 16'h0000;
    endcase
end

////////////////////////////////////////////////////////////////////////////////
always @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
        state_q <= S_IDLE;
        ret_q <= S_IDLE;
        rdw_q <= 1'b0;
        rd_q <= 8'h00;
        cr_q <= 8'h00;
        dev_addr_q <= 8'h00;
        dev_wdata_q <= 8'h00;
        dev_wr_q <= 1'b0;
        dev_rd_q <= 1'b0;
        h_rdata_q <= 16'h0000;
        rnw_q <= 1'b0;
        hold_q <= 1'b0;
        slv_en_q <= 1'b0;
        en_q <= 1'b0;
        div_q <= 6'h00;
        own_q <= 7'h00;
        tgt_q <= 7'h00;
        len_q <= 8'h00;
        cnt_q <= 8'h00;
        txd_q <= 8'h00;
        rxd_q <= 8'h00;
        tx_full_q <= 1'b0;
        rx_full_q <= 1'b0;
        done_q <= 1'b0;
        nack_q <= 1'b0;
        al_q <= 1'b0;
        master_q <= 1'b0;
        slave_q <= 1'b0;
        holding_q <= 1'b0;
        addr_ph_q <= 1'b0;
        mrnw_q <= 1'b0;
        mhold_q <= 1'b0;
        dummy_q <= 1'b0;
        last_q <= 1'b0;
    end else begin
        dev_wr_q <= 1'b0;
        dev_rd_q <= 1'b0;
        // host side; status sets further down win over these clears
        if (h_wr_in) begin
            case (h_addr_in)
                `TWBC_H_CTRL: begin
                    rnw_q <= h_wdata_in[`TWBC_C_RNW];
                    hold_q <= h_wdata_in[`TWBC_C_HOLD];
                    slv_en_q <= h_wdata_in[`TWBC_C_SLVEN];
                end
                `TWBC_H_CFG: begin
                    div_q <= h_wdata_in[5:0];
                    own_q <= h_wdata_in[14:8];
                end
                `TWBC_H_TGT: tgt_q <= h_wdata_in[6:0];
                `TWBC_H_LEN: len_q <= h_wdata_in[7:0];
                `TWBC_H_TXD: begin
                    txd_q <= h_wdata_in[7:0];
                    tx_full_q <= 1'b1;
                end
                `TWBC_H_STAT: begin
                    if (h_wdata_in[`TWBC_S_DONE]) done_q <= 1'b0;
                    if (h_wdata_in[`TWBC_S_NACK]) nack_q <= 1'b0;
                    if (h_wdata_in[`TWBC_S_AL]) al_q <= 1'b0;
                end
                default: ;
            endcase
        end
        if (h_rd_in) begin
            h_rdata_q <= rmux;
            if (h_addr_in == `TWBC_H_RXD) rx_full_q <= 1'b0;
        end
        case (state_q)
            S_IDLE: begin
                if (init_w) begin
                    dev_addr_q <= `TWBC_D_FDR;
                    dev_wdata_q <= {2'b00, div_q};
                    dev_wr_q <= 1'b1;
                    state_q <= S_INIT2;
                end else if (start_w && en_q) begin
                    master_q <= 1'b1;
                    slave_q <= 1'b0;
                    addr_ph_q <= 1'b1;
                    last_q <= 1'b0;
                    cnt_q <= len_q;
                    mrnw_q <= h_wdata_in[`TWBC_C_RNW];
                    mhold_q <= h_wdata_in[`TWBC_C_HOLD];
                    if (holding_q) begin
                        // bus still ours: repeated start, no stop first
                        cr_q[`TWBC_CR_DIR] <= 1'b1;
                        cr_q[`TWBC_CR_NOACK] <= 1'b0;
                        dev_addr_q <= `TWBC_D_CR;
                        dev_wdata_q <= {cr_q[7:5], 2'b10, 3'b000} |
                            (8'h01 << `TWBC_CR_RSTART);
                        dev_wr_q <= 1'b1;
                        state_q <= S_ADDR;
                    end else begin
                        dev_addr_q <= `TWBC_D_SR;
                        dev_rd_q <= 1'b1;
                        ret_q <= S_BBCHK;
                        state_q <= S_RDW;
                    end
                end else if (slv_en_q && en_q && !holding_q) begin
                    slave_q <= 1'b1;
                    dev_addr_q <= `TWBC_D_SR;
                    dev_rd_q <= 1'b1;
                    ret_q <= S_PCHK;
                    state_q <= S_RDW;
                end
            end
            S_INIT2: begin
                dev_addr_q <= `TWBC_D_ADR;
                dev_wdata_q <= {own_q, 1'b0};
                dev_wr_q <= 1'b1;
                cr_q <= 8'h01 << `TWBC_CR_EN;
                en_q <= 1'b1;
                ret_q <= S_IDLE;
                state_q <= S_CRW;
            end
            S_CRW: begin
                dev_addr_q <= `TWBC_D_CR;
                dev_wdata_q <= cr_q;
                dev_wr_q <= 1'b1;
                state_q <= ret_q;
            end
            S_RDW: begin
                // data stand one cycle after the strobe cycle
                rdw_q <= ~rdw_q;
                if (rdw_q) begin
                    rd_q <= dev_rdata_in;
                    state_q <= ret_q;
                end
            end
            S_BBCHK: begin
                if (rd_q[`TWBC_SR_BUSY]) begin
                    dev_addr_q <= `TWBC_D_SR;
                    dev_rd_q <= 1'b1;
                    state_q <= S_RDW;
                end else begin
                    cr_q <= (8'h01 << `TWBC_CR_EN) | (8'h01 << `TWBC_CR_DIR);
                    ret_q <= S_STA;
                    state_q <= S_CRW;
                end
            end
            S_STA: begin
                cr_q[`TWBC_CR_MSEL] <= 1'b1;
                ret_q <= S_ADDR;
                state_q <= S_CRW;
            end
            S_ADDR: begin
                dev_addr_q <= `TWBC_D_DR;
                dev_wdata_q <= {tgt_q, mrnw_q};
                dev_wr_q <= 1'b1;
                holding_q <= 1'b0;
                ret_q <= S_BB2CHK;
                state_q <= S_POLL;
            end
            S_BB2CHK: begin
                // slow bus clock: busy may lag the address write
                if (rd_q[`TWBC_SR_BUSY] || rd_q[`TWBC_SR_IP])
                    state_q <= S_PCHK;
                else
                    state_q <= S_POLL;
            end
            S_POLL: begin
                dev_addr_q <= `TWBC_D_SR;
                dev_rd_q <= 1'b1;
                state_q <= S_RDW;
            end
            S_PCHK: begin
                if (rd_q[`TWBC_SR_IP]) begin
                    dev_addr_q <= `TWBC_D_SR;
                    dev_wdata_q <= 8'h00;
                    dev_wr_q <= 1'b1;
                    state_q <= S_DISP;
                end else if (slave_q) begin
                    slave_q <= 1'b0;
                    state_q <= S_IDLE;
                end else begin
                    ret_q <= S_PCHK;
                    state_q <= S_POLL;
                end
            end
            S_DISP: begin
                if (rd_q[`TWBC_SR_AL]) begin
                    // device already dropped master-select; mirror it
                    al_q <= 1'b1;
                    cr_q[`TWBC_CR_MSEL] <= 1'b0;
                    cr_q[`TWBC_CR_DIR] <= 1'b0;
                    if (master_q) done_q <= 1'b1;
                    master_q <= 1'b0;
                    slave_q <= 1'b0;
                    holding_q <= 1'b0;
                    state_q <= S_IDLE;
                end else if (slave_q) begin
                    if (rd_q[`TWBC_SR_AAS]) begin
                        cr_q[`TWBC_CR_DIR] <= rd_q[`TWBC_SR_SRW];
                        cr_q[`TWBC_CR_NOACK] <= 1'b0;
                        dummy_q <= 1'b1;
                        ret_q <= rd_q[`TWBC_SR_SRW] ? S_TXB : S_RXRD;
                        state_q <= S_CRW;
                    end else if (cr_q[`TWBC_CR_DIR]) begin
                        if (rd_q[`TWBC_SR_RECEIVED_ACK_FLAG]) begin
                            cr_q[`TWBC_CR_DIR] <= 1'b0;
                            dummy_q <= 1'b1;
                            ret_q <= S_RXRD;
                            state_q <= S_CRW;
                        end else begin
                            state_q <= S_TXB;
                        end
                    end else begin
                        dummy_q <= 1'b0;
                        state_q <= S_RXRD;
                    end
                end else if (addr_ph_q) begin
                    addr_ph_q <= 1'b0;
                    if (rd_q[`TWBC_SR_RECEIVED_ACK_FLAG]) begin
                        nack_q <= 1'b1;
                        state_q <= S_STOP;
                    end else if (cnt_q == 8'h00) begin
                        state_q <= S_FIN;
                    end else if (mrnw_q) begin
                        cr_q[`TWBC_CR_DIR] <= 1'b0;
                        cr_q[`TWBC_CR_NOACK] <= (cnt_q == 8'h01);
                        dummy_q <= 1'b1;
                        ret_q <= S_RXRD;
                        state_q <= S_CRW;
                    end else begin
                        state_q <= S_TXB;
                    end
                end else if (cr_q[`TWBC_CR_DIR]) begin
                    if (rd_q[`TWBC_SR_RECEIVED_ACK_FLAG]) begin
                        nack_q <= 1'b1;
                        state_q <= S_STOP;
                    end else if (cnt_q == 8'h00) begin
                        state_q <= S_FIN;
                    end else begin
                        state_q <= S_TXB;
                    end
                end else begin
                    cnt_q <= cnt_q - 8'h01;
                    dummy_q <= 1'b0;
                    if (cnt_q == 8'h01) begin
                        last_q <= 1'b1;
                        state_q <= S_STOP;
                    end else if (cnt_q == 8'h02) begin
                        cr_q[`TWBC_CR_NOACK] <= 1'b1;
                        ret_q <= S_RXRD;
                        state_q <= S_CRW;
                    end else begin
                        state_q <= S_RXRD;
                    end
                end
            end
            S_TXB: begin
                // stalls until software supplies the byte
                if (tx_full_q) begin
                    dev_addr_q <= `TWBC_D_DR;
                    dev_wdata_q <= txd_q;
                    dev_wr_q <= 1'b1;
                    tx_full_q <= 1'b0;
                    if (master_q) cnt_q <= cnt_q - 8'h01;
                    if (slave_q) begin
                        slave_q <= 1'b0;
                        state_q <= S_IDLE;
                    end else begin
                        ret_q <= S_PCHK;
                        state_q <= S_POLL;
                    end
                end
            end
            S_RXRD: begin
                dev_addr_q <= `TWBC_D_DR;
                dev_rd_q <= 1'b1;
                ret_q <= S_RXST;
                state_q <= S_RDW;
            end
            S_RXST: begin
                // byte kept in rd_q until software empties the receive slot
                if (dummy_q || !rx_full_q) begin
                    if (!dummy_q) begin
                        rxd_q <= rd_q;
                        rx_full_q <= 1'b1;
                    end
                    if (last_q) begin
                        last_q <= 1'b0;
                        state_q <= S_DONE;
                    end else if (slave_q) begin
                        slave_q <= 1'b0;
                        state_q <= S_IDLE;
                    end else begin
                        ret_q <= S_PCHK;
                        state_q <= S_POLL;
                    end
                end
            end
            S_STOP: begin
                cr_q[`TWBC_CR_MSEL] <= 1'b0;
                cr_q[`TWBC_CR_DIR] <= 1'b0;
                cr_q[`TWBC_CR_NOACK] <= 1'b0;
                master_q <= 1'b0;
                holding_q <= 1'b0;
                dummy_q <= 1'b0;
                ret_q <= last_q ? S_RXRD : S_DONE;
                state_q <= S_CRW;
            end
            S_FIN: begin
                if (mhold_q) begin
                    holding_q <= 1'b1;
                    state_q <= S_DONE;
                end else begin
                    state_q <= S_STOP;
                end
            end
            S_DONE: begin
                done_q <= 1'b1;
                state_q <= S_IDLE;
            end
            default: state_q <= S_IDLE;
        endcase
    end
end

endmodule // twbc_ctrl
`default_nettype wire

//--- logic/twbc_defs.vh
// constants for the two-wire bus host sequencer
`ifndef TWBC_DEFS_VH
`define TWBC_DEFS_VH
// host-side register offsets
`define TWBC_H_CTRL 8'h00
`define TWBC_H_CFG 8'h04
`define TWBC_H_TGT 8'h08
`define TWBC_H_LEN 8'h0C
`define TWBC_H_TXD 8'h10
`define TWBC_H_RXD 8'h14
`define TWBC_H_STAT 8'h18
// host control fields
`define TWBC_C_START 0
`define TWBC_C_RNW 1
`define TWBC_C_HOLD 2
`define TWBC_C_INIT 3
`define TWBC_C_SLVEN 4
// host status fields
`define TWBC_S_BUSY 0
`define TWBC_S_DONE 1
`define TWBC_S_NACK 2
`define TWBC_S_AL 3
`define TWBC_S_TXF 4
`define TWBC_S_RXF 5
`define TWBC_S_HELD 6
`define TWBC_S_EN 7
// device register offsets
`define TWBC_D_ADR 8'h00
`define TWBC_D_FDR 8'h04
`define TWBC_D_CR 8'h08
`define TWBC_D_SR 8'h0C
`define TWBC_D_DR 8'h10
// device control bits
`define TWBC_CR_EN 7
`define TWBC_CR_IEN 6
`define TWBC_CR_MSEL 5
`define TWBC_CR_DIR 4
`define TWBC_CR_NOACK 3
`define TWBC_CR_RSTART 2
// device status bits
`define TWBC_SR_DONE 7
`define TWBC_SR_AAS 6
`define TWBC_SR_BUSY 5
`define TWBC_SR_AL 4
`define TWBC_SR_SRW 2
`define TWBC_SR_IP 1
`define TWBC_SR_RECEIVED_ACK_FLAG 0
`endif

//--- dv/twbc_props.sv
// concurrent checks on the host sequencer ports
`timescale 1ns/1ps
`default_nettype none
`include "twbc_defs.vh"
module twbc_props (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] h_addr_in,
    input wire logic [15:0] h_wdata_in,
    input wire logic h_wr_in,
    input wire logic h_rd_in,
    input wire logic [15:0] h_rdata_out,
    input wire logic [7:0] dev_addr_out,
    input wire logic [7:0] dev_wdata_out,
    input wire logic dev_wr_out,
    input wire logic dev_rd_out,
    input wire logic [7:0] dev_rdata_in
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    ////////////////////////////////////////
    logic [7:0] cr_q;
    logic [6:0] tgt_q;
    logic rnw_q, srd_q, busy_q, pend_q;
    wire cr_w = dev_wr_out && dev_addr_out == `TWBC_D_CR;
    wire dr_w = dev_wr_out && dev_addr_out == `TWBC_D_DR;
    wire rise = cr_w && dev_wdata_out[`TWBC_CR_MSEL] && !cr_q[`TWBC_CR_MSEL];
    // last control byte written, as seen from the port
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            {cr_q, tgt_q, rnw_q, srd_q, busy_q, pend_q} <= '0;
        end else begin
            srd_q <= dev_rd_out && dev_addr_out == `TWBC_D_SR;
            if (srd_q) busy_q <= dev_rdata_in[`TWBC_SR_BUSY];
            if (cr_w) cr_q <= dev_wdata_out;
            if (h_wr_in && h_addr_in == `TWBC_H_TGT) tgt_q <= h_wdata_in[6:0];
            if (h_wr_in && h_addr_in == `TWBC_H_CTRL && h_wdata_in[0]) rnw_q <= h_wdata_in[1];
            if (rise || (cr_w && dev_wdata_out[`TWBC_CR_RSTART])) pend_q <= 1'b1;
            else if (dr_w) pend_q <= 1'b0;
        end
    end
    ////////////////////////////////////////
    a_rdata_holds: assert property (!$past(h_rd_in) |-> $stable(h_rdata_out))
        else $error("host read data moved without a read");
    a_unmapped_zero: assert property (h_rd_in && h_addr_in == 8'h1C |=> h_rdata_out == 16'h0000)
        else $error("unmapped read not zero");
    a_read_gap: assert property (dev_rd_out |=> !dev_wr_out && !dev_rd_out)
        else $error("device access right after a read");
    a_init_order: assert property (
        dev_wr_out && dev_addr_out == `TWBC_D_FDR |=> dev_wr_out && dev_addr_out == `TWBC_D_ADR
        ##1 cr_w && dev_wdata_out == 8'h80) else $error("init order broken");
    a_start_free: assert property (rise |-> !busy_q)
        else $error("start issued while bus busy");
    a_tx_first: assert property (cr_w && dev_wdata_out == 8'hB0 |-> cr_q == 8'h90)
        else $error("start not preceded by transmit mode");
    a_calling_addr: assert property (dr_w && pend_q |-> dev_wdata_out == {tgt_q, rnw_q})
        else $error("calling address wrong");
    a_sr_zero: assert property (dev_wr_out && dev_addr_out == `TWBC_D_SR |-> dev_wdata_out == 8'h00)
        else $error("status cleared with nonzero value");
    a_rx_read: assert property (
        dev_rd_out && dev_addr_out == `TWBC_D_DR && cr_q[`TWBC_CR_MSEL] |-> !cr_q[`TWBC_CR_DIR])
        else $error("data read in master transmit mode");
    a_tx_write: assert property (dr_w |-> cr_q[`TWBC_CR_DIR])
        else $error("data written in receive mode");
endmodule // twbc_props
bind twbc_ctrl twbc_props props_u (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .h_addr_in(h_addr_in),
    .h_wdata_in(h_wdata_in),
    .h_wr_in(h_wr_in),
    .h_rd_in(h_rd_in),
    .h_rdata_out(h_rdata_out),
    .dev_addr_out(dev_addr_out),
    .dev_wdata_out(dev_wdata_out),
    .dev_wr_out(dev_wr_out),
    .dev_rd_out(dev_rd_out),
    .dev_rdata_in(dev_rdata_in)
);
`default_nettype wire

//--- dv/twbc_dev.sv
// behavioural model of the bus controller device registers
`timescale 1ns/1ps
`default_nettype none
`include "twbc_defs.vh"
module twbc_dev #(parameter int BYTE_T = 20, parameter int GAP_T = 6) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic nack_in,
    input wire logic lose_in,
    output logic [7:0] rdata_out,
    output logic [7:0] adr_out,
    output logic [7:0] fdr_out,
    output logic [7:0] tx_out,
    output logic [7:0] txn_out,
    output logic [7:0] stops_out,
    output logic [7:0] rsts_out
);
    logic [7:0] cr_q, sr_q, dr_q, rx_q;
    int t_q, g_q;
    logic al_q;
    ////////////////////////////////////////
    always @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            {rdata_out, adr_out, fdr_out, tx_out, txn_out, stops_out, rsts_out} <= '0;
            {cr_q, dr_q, t_q, g_q, al_q} <= '0;
            sr_q <= 8'h81;
            rx_q <= 8'hC0;
        end else begin
            // inverted so a late sample never sees stale data
            rdata_out <= ~rdata_out;
            if (g_q > 0) g_q <= g_q - 1;
            if (g_q == 1) sr_q[5] <= cr_q[5];
            if (t_q > 0) t_q <= t_q - 1;
            if (t_q == 1) begin
                sr_q[7] <= 1'b1;
                sr_q[1] <= 1'b1;
                sr_q[0] <= cr_q[4] & nack_in;
                if (!cr_q[4]) dr_q <= rx_q;
                if (!cr_q[4]) rx_q <= rx_q + 8'h01;
                if (al_q) begin
                    sr_q[4] <= 1'b1;
                    cr_q[5:4] <= 2'b00;
                    g_q <= GAP_T;
                end
            end
            if (rd_in) begin
                case (addr_in)
                    `TWBC_D_ADR: rdata_out <= adr_out;
                    `TWBC_D_FDR: rdata_out <= fdr_out;
                    `TWBC_D_CR: rdata_out <= cr_q;
                    `TWBC_D_SR: rdata_out <= sr_q;
                    `TWBC_D_DR: rdata_out <= dr_q;
                    default: rdata_out <= 8'h00;
                endcase
                if (addr_in == `TWBC_D_DR && !cr_q[4]) begin
                    sr_q[7] <= 1'b0;
                    if (cr_q[5]) t_q <= BYTE_T;
                end
            end
            if (wr_in) begin
                case (addr_in)
                    `TWBC_D_ADR: adr_out <= wdata_in;
                    `TWBC_D_FDR: fdr_out <= wdata_in;
                    `TWBC_D_SR: begin
                        sr_q[4] <= sr_q[4] & wdata_in[4];
                        sr_q[1] <= sr_q[1] & wdata_in[1];
                    end
                    `TWBC_D_CR: begin
                        cr_q <= {wdata_in[7:3], 3'b000}; // restart bit reads low
                        sr_q[6] <= 1'b0;
                        if (wdata_in[5] != cr_q[5]) g_q <= GAP_T;
                        if (!wdata_in[5] && cr_q[5]) stops_out <= stops_out + 8'h01;
                        if (wdata_in[2] && cr_q[5]) rsts_out <= rsts_out + 8'h01;
                    end
                    `TWBC_D_DR: if (cr_q[4]) begin
                        tx_out <= wdata_in;
                        txn_out <= txn_out + 8'h01;
                        sr_q[7] <= 1'b0;
                        al_q <= lose_in;
                        t_q <= BYTE_T;
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule // twbc_dev
`default_nettype wire

//--- dv/twbc_ctrl_tb.sv
// self-checking bench for the two-wire bus host sequencer
`timescale 1ns/1ps
`default_nettype none
`include "twbc_defs.vh"
module twbc_ctrl_tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] h_addr_in = 8'h00;
    logic [15:0] h_wdata_in = 16'h0000;
    logic h_wr_in = 1'b0;
    logic h_rd_in = 1'b0;
    logic nack = 1'b0;
    logic lose = 1'b0;
    logic [15:0] h_rdata_out, rx_n = 16'h0000;
    logic [7:0] dev_addr_out, dev_wdata_out, dev_rdata_in, adr, fdr, tx, txn, stops, rsts;
    logic dev_wr_out, dev_rd_out;
    logic [7:0] t0, s0, r0;
    int error_cnt = 0;
    int samples_checked = 0;
    always #20 clk_in = ~clk_in;
    twbc_ctrl dut_u (.clk_in, .rst_in, .h_addr_in, .h_wdata_in, .h_wr_in, .h_rd_in,
        .h_rdata_out, .dev_addr_out, .dev_wdata_out, .dev_wr_out, .dev_rd_out, .dev_rdata_in);
    twbc_dev part_u (.clk_in(clk_in), .rst_in(rst_in), .addr_in(dev_addr_out),
        .wdata_in(dev_wdata_out), .wr_in(dev_wr_out), .rd_in(dev_rd_out), .nack_in(nack),
        .lose_in(lose), .rdata_out(dev_rdata_in), .adr_out(adr), .fdr_out(fdr), .tx_out(tx),
        .txn_out(txn), .stops_out(stops), .rsts_out(rsts));
    ////////////////////////////////////////
    task automatic hw(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        h_addr_in <= a;
        h_wdata_in <= d;
        h_wr_in <= 1'b1;
        @(posedge clk_in);
        h_wr_in <= 1'b0;
    endtask
    task automatic hr(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_in);
        h_addr_in <= a;
        h_rd_in <= 1'b1;
        @(posedge clk_in);
        h_rd_in <= 1'b0;
        @(negedge clk_in);
        d = h_rdata_out;
    endtask
    task automatic check(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    // every wait is bounded so a stuck sequencer ends the run
    task automatic wait_st(input int b, input logic v);
        logic [15:0] s;
        for (int i = 0; i < 2000; i++) begin
            hr(`TWBC_H_STAT, s);
            if (s[b] === v) return;
        end
        $display("wrong value status bit %0d expected %b seen %b", b, v, s[b]);
        error_cnt++;
        summarize();
    endtask
    task automatic snap();
        t0 = txn;
        s0 = stops;
        r0 = rsts;
    endtask
    task automatic bus_chk(input logic [7:0] nt, lt, ns, nr);
        check("tx bytes", {8'h00, nt}, {8'h00, txn - t0});
        check("last tx", {8'h00, lt}, {8'h00, tx});
        check("stops", {8'h00, ns}, {8'h00, stops - s0});
        check("restarts", {8'h00, nr}, {8'h00, rsts - r0});
    endtask
    // shared master transfer; all n bytes are pushed on writes, the first before the start
    task automatic xfer(input logic rnw, hold, input logic [7:0] n, output logic [15:0] st);
        logic [15:0] d;
        hw(`TWBC_H_LEN, {8'h00, n});
        if (!rnw) hw(`TWBC_H_TXD, 16'h00A0);
        hw(`TWBC_H_CTRL, {13'h0000, hold, rnw, 1'b1});
        for (int k = 0; k < n; k++) begin
            if (rnw) begin
                wait_st(`TWBC_S_RXF, 1'b1);
                hr(`TWBC_H_RXD, d);
                check("rx byte", 16'h00C0 + rx_n, d);
                rx_n++;
            end else if (k + 1 < n) begin
                wait_st(`TWBC_S_TXF, 1'b0);
                hw(`TWBC_H_TXD, 16'h00A1);
            end
        end
        wait_st(`TWBC_S_DONE, 1'b1);
        hr(`TWBC_H_STAT, st);
        hw(`TWBC_H_STAT, 16'h000E);
    endtask
    ////////////////////////////////////////
    task automatic t_init();
        hw(`TWBC_H_CFG, 16'h2A15);
        hw(`TWBC_H_CTRL, 16'h0008);
        wait_st(`TWBC_S_EN, 1'b1);
        check("divider", 16'h0015, {8'h00, fdr});
        check("own address", 16'h0054, {8'h00, adr});
    endtask
    task automatic t_write();
        logic [15:0] st;
        hw(`TWBC_H_TGT, 16'h0055);
        snap();
        xfer(1'b0, 1'b0, 8'h02, st);
        bus_chk(8'h03, 8'hA1, 8'h01, 8'h00);
        check("nack flag", 16'h0000, {15'h0000, st[`TWBC_S_NACK]});
    endtask
    task automatic t_nack();
        logic [15:0] st;
        nack <= 1'b1;
        snap();
        xfer(1'b0, 1'b0, 8'h01, st);
        nack <= 1'b0;
        bus_chk(8'h01, 8'hAA, 8'h01, 8'h00);
        check("nack flag", 16'h0001, {15'h0000, st[`TWBC_S_NACK]});
    endtask
    task automatic t_read();
        logic [15:0] st;
        hw(`TWBC_H_TGT, 16'h0033);
        snap();
        xfer(1'b1, 1'b0, 8'h02, st);
        bus_chk(8'h01, 8'h67, 8'h01, 8'h00);
    endtask
    task automatic t_restart();
        logic [15:0] st;
        hw(`TWBC_H_TGT, 16'h0011);
        snap();
        xfer(1'b0, 1'b1, 8'h01, st);
        check("held", 16'h0001, {15'h0000, st[`TWBC_S_HELD]});
        xfer(1'b1, 1'b0, 8'h01, st);
        bus_chk(8'h03, 8'h23, 8'h01, 8'h01);
    endtask
    task automatic t_arb();
        logic [15:0] st;
        lose <= 1'b1;
        snap();
        xfer(1'b0, 1'b0, 8'h01, st);
        lose <= 1'b0;
        check("arb lost", 16'h0001, {15'h0000, st[`TWBC_S_AL]});
        bus_chk(8'h01, 8'h22, 8'h00, 8'h00);
        hr(`TWBC_H_STAT, st);
        check("flags cleared", 16'h0000, st & 16'h000E);
        hr(8'h1C, st);
        check("unmapped", 16'h0000, st);
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        t_init();
        t_write();
        t_nack();
        t_read();
        t_restart();
        t_arb();
        t_read();
        summarize();
    end
endmodule // twbc_ctrl_tb
`default_nettype wire
